// ---- inc/dtss_map.vh ----
// Purpose: register offsets, field positions, reset values and timing counts of the dual slot sequencer
// Assumes: classic wishbone, 32-bit data, one aligned word per register
// Notes:   printed offsets are not all multiples of four, so byte address = 4 * index
`ifndef DTSS_MAP_VH
`define DTSS_MAP_VH

// ============================================================
// register indices
`define DTSS_IDX_RATE        8'h12
`define DTSS_IDX_SWITCH      8'h14
`define DTSS_IDX_A_DELAY     8'h30
`define DTSS_IDX_A_PULSE     8'h31
`define DTSS_IDX_B_DELAY     8'h35
`define DTSS_IDX_B_PULSE     8'h36
`define DTSS_IDX_CTRL        8'h40
`define DTSS_IDX_STATUS      8'h41
`define DTSS_IDX_A_RESULT    8'h42
`define DTSS_IDX_B_RESULT    8'h43
`define DTSS_IDX_FIFO        8'h44

// ============================================================
// field positions
`define DTSS_CNT_HI          15
`define DTSS_CNT_LO          8
`define DTSS_LOW_HI          7
`define DTSS_LOW_LO          0
`define DTSS_SW_B_HI         11
`define DTSS_SW_B_LO         8
`define DTSS_SW_A_HI         7
`define DTSS_SW_A_LO         4
`define DTSS_CTRL_RUN        0
`define DTSS_CTRL_A_EN       1
`define DTSS_CTRL_B_EN       2

// ============================================================
// reset values
`define DTSS_RST_RATE        16'h0020
`define DTSS_RST_SWITCH      16'h0000
`define DTSS_RST_DELAY       16'h0020
`define DTSS_RST_PULSE       16'h0113
`define DTSS_RST_CTRL        3'h6

// ============================================================
// timing: clock rate, microsecond tick, sample tick, fixed intervals
`define DTSS_CLK_HZ          125000000
`define DTSS_US_CYC          (`DTSS_CLK_HZ / 1000000)
`define DTSS_SAMPLE_HZ       32000
`define DTSS_SAMPLE_CYC      ((`DTSS_CLK_HZ + `DTSS_SAMPLE_HZ - 1) / `DTSS_SAMPLE_HZ)
`define DTSS_T1_US           68
`define DTSS_T2_US           20
`define DTSS_SLEEP_MIN_US    222
`define DTSS_EMIT_WIDTH_US   4

`endif

// ---- src/dtss_input_switch.v ----
// Purpose: per-slot routing of eight photodiode inputs onto four channels
// Assumes: input is one 4-bit switch code per slot, channel outputs are connect masks
// Notes:   bit k of a channel mask set means photodiode input k+1 is tied to that channel
`timescale 1ns/1ns
module dtss_input_switch (
  input  wire [3:0] code_i,
  output reg  [7:0] ch1_o,
  output reg  [7:0] ch2_o,
  output reg  [7:0] ch3_o,
  output reg  [7:0] ch4_o
);
  always @* begin
    ch1_o = 8'h00;
    ch2_o = 8'h00;
    ch3_o = 8'h00;
    ch4_o = 8'h00;
    case (code_i)
      4'h1: begin
        ch1_o = 8'h0C;
        ch2_o = 8'h03;
      end
      4'h2: begin
        ch1_o = 8'hC0;
        ch2_o = 8'h30;
      end
      4'h3: ch1_o = 8'h0F;
      4'h4: begin
        ch1_o = 8'h10;
        ch2_o = 8'h20;
        ch3_o = 8'h40;
        ch4_o = 8'h80;
      end
      4'h5: begin
        ch1_o = 8'h01;
        ch2_o = 8'h02;
        ch3_o = 8'h04;
        ch4_o = 8'h08;
      end
      4'h6: begin
        ch1_o = 8'h0C;
        ch2_o = 8'h30;
      end
      4'h7: ch1_o = 8'hF0;
      // code 0 and unlisted codes leave all open
      default: ch1_o = 8'h00;
    endcase
  end
endmodule

// ---- src/dtss_sequencer.v ----
// Purpose: dual time slot sequencer with wishbone register file
// Assumes: classic wishbone slave, one clock, synchronous active-low reset
// Notes:   durations counted in microseconds of a 125 MHz clock, sample timer in 32 kHz ticks
`timescale 1ns/1ns
`include "dtss_map.vh"
module dtss_sequencer (
  input  wire        MCLK_I,
  input  wire        RST_N_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [9:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire [15:0] ADC_DATA_I,
  output reg         SLOT_A_EMITTER_PULSE_O,
  output reg         SLOT_B_EMITTER_PULSE_O,
  output reg         FRONT_END_ON_O,
  output reg         SLOT_B_ACTIVE_O,
  output wire [7:0]  CH1_SEL_O,
  output wire [7:0]  CH2_SEL_O,
  output wire [7:0]  CH3_SEL_O,
  output wire [7:0]  CH4_SEL_O
);
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_DELAY  = 3'd1;
  localparam [2:0] ST_PULSE  = 3'd2;
  localparam [2:0] ST_GAP    = 3'd3;
  localparam [2:0] ST_CALC   = 3'd4;
  localparam [2:0] ST_SLEEP  = 3'd5;
  localparam integer US_CYC_N   = `DTSS_US_CYC;
  localparam integer TICK_CYC_N = `DTSS_SAMPLE_CYC;
  localparam [6:0] US_CYC    = US_CYC_N[6:0];
  localparam [12:0] TICK_CYC = TICK_CYC_N[12:0];
  localparam [7:0] T1_US     = `DTSS_T1_US;
  localparam [7:0] T2_US     = `DTSS_T2_US;
  localparam [7:0] SLEEP_US  = `DTSS_SLEEP_MIN_US;
  localparam [7:0] WIDTH_US  = `DTSS_EMIT_WIDTH_US;
  localparam       FIFO_AW   = 3;

  // ============================================================
  // register file
  reg [15:0] rate_ff;
  reg [15:0] switch_ff;
  reg [15:0] a_delay_ff;
  reg [15:0] a_pulse_ff;
  reg [15:0] b_delay_ff;
  reg [15:0] b_pulse_ff;
  reg [2:0]  ctrl_ff;
  reg [15:0] a_result_ff;
  reg [15:0] b_result_ff;
  reg        ack_ff;
  reg [16:0] fifo_mem [0:(1<<FIFO_AW)-1];
  reg [FIFO_AW:0] wr_ptr_ff;
  reg [FIFO_AW:0] rd_ptr_ff;

  wire       req     = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire [7:0] idx     = WB_ADR_I[9:2];
  wire       wr_go   = req & WB_WE_I;
  wire       rd_go   = req & ~WB_WE_I;
  wire       f_empty = (wr_ptr_ff == rd_ptr_ff);
  wire       f_full  = (wr_ptr_ff[FIFO_AW] != rd_ptr_ff[FIFO_AW]) &&
                       (wr_ptr_ff[FIFO_AW-1:0] == rd_ptr_ff[FIFO_AW-1:0]);

  assign WB_ACK_O = ack_ff;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] din;
    input [3:0]  sel;
    begin
      merge16[7:0]  = sel[0] ? din[7:0]  : old[7:0];
      merge16[15:8] = sel[1] ? din[15:8] : old[15:8];
    end
  endfunction

  // ============================================================
  // sequencer state
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg        slot_b_ff;
  reg [7:0]  us_left_ff;
  reg [7:0]  nxt_us_left;
  reg [7:0]  pulses_left_ff;
  reg [7:0]  nxt_pulses_left;
  reg [6:0]  us_div_ff;
  reg [12:0] tick_div_ff;
  reg [15:0] rate_cnt_ff;
  reg        sleep_done_ff;

  wire us_tick     = (us_div_ff == US_CYC - 7'd1);
  wire sample_tick = (tick_div_ff == TICK_CYC - 13'd1);
  wire run         = ctrl_ff[`DTSS_CTRL_RUN];
  wire a_en        = ctrl_ff[`DTSS_CTRL_A_EN];
  wire b_en        = ctrl_ff[`DTSS_CTRL_B_EN];
  // period expiry from 16-bit rate field
  wire expiry      = run & sample_tick & (rate_cnt_ff == 16'h0000);

  wire [15:0] cur_delay = slot_b_ff ? b_delay_ff : a_delay_ff;
  wire [15:0] cur_pulse = slot_b_ff ? b_pulse_ff : a_pulse_ff;
  wire [7:0]  delay_us  = cur_delay[`DTSS_LOW_HI:`DTSS_LOW_LO];
  wire [7:0]  space_us  = cur_pulse[`DTSS_LOW_HI:`DTSS_LOW_LO];
  wire [7:0]  count_n   = cur_pulse[`DTSS_CNT_HI:`DTSS_CNT_LO];
  wire        last_us   = us_tick & (us_left_ff <= 8'd1);
  // capture while slot_b_ff still names the finishing slot
  wire        capture_go = (state_ff == ST_CALC) & last_us;
  // restart microsecond divider so the first pulse delay is exact
  wire        slot_start = ((state_ff == ST_IDLE) || (state_ff == ST_SLEEP)) && (nxt_state == ST_DELAY);

  function [7:0] low_gap;
    input [7:0] spacing;
    begin
      low_gap = (spacing > WIDTH_US) ? (spacing - WIDTH_US) : 8'd1;
    end
  endfunction

  always @* begin
    nxt_state       = state_ff;
    nxt_us_left     = us_left_ff;
    nxt_pulses_left = pulses_left_ff;
    if (us_tick && us_left_ff != 8'd0) begin
      nxt_us_left = us_left_ff - 8'd1;
    end
    case (state_ff)
      ST_IDLE: begin
        // start first enabled slot on expiry
        if (expiry && (a_en || b_en)) begin
          nxt_state   = ST_DELAY;
          nxt_us_left = (a_en ? a_delay_ff[7:0] : b_delay_ff[7:0]);
        end
      end
      ST_DELAY: begin
        if (last_us) begin
          nxt_state       = ST_PULSE;
          nxt_us_left     = WIDTH_US;
          nxt_pulses_left = (count_n == 8'd0) ? 8'd1 : count_n;
        end
      end
      ST_PULSE: begin
        if (last_us) begin
          nxt_state       = ST_GAP;
          nxt_us_left     = low_gap(space_us);
          nxt_pulses_left = pulses_left_ff - 8'd1;
        end
      end
      ST_GAP: begin
        if (last_us) begin
          if (pulses_left_ff != 8'd0) begin
            nxt_state   = ST_PULSE;
            nxt_us_left = WIDTH_US;
          end else begin
            nxt_state   = ST_CALC;
            nxt_us_left = slot_b_ff ? T2_US : T1_US;
          end
        end
      end
      ST_CALC: begin
        if (last_us) begin
          // slot B follows A only when enabled
          if (!slot_b_ff && b_en) begin
            nxt_state   = ST_DELAY;
            nxt_us_left = b_delay_ff[7:0];
          end else begin
            nxt_state   = ST_SLEEP;
            nxt_us_left = SLEEP_US;
          end
        end
      end
      ST_SLEEP: begin
        // minimum sleep, then wait for next expiry
        if (sleep_done_ff && expiry) begin
          nxt_state   = (a_en || b_en) ? ST_DELAY : ST_IDLE;
          nxt_us_left = a_en ? a_delay_ff[7:0] : b_delay_ff[7:0];
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!run) begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_ff       <= ST_IDLE;
      slot_b_ff      <= 1'b0;
      us_left_ff     <= 8'd0;
      pulses_left_ff <= 8'd0;
      us_div_ff      <= 7'd0;
      tick_div_ff    <= 13'd0;
      rate_cnt_ff    <= 16'h0000;
      sleep_done_ff  <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      us_left_ff     <= nxt_us_left;
      pulses_left_ff <= nxt_pulses_left;
      us_div_ff      <= (us_tick || slot_start) ? 7'd0 : us_div_ff + 7'd1;
      tick_div_ff    <= sample_tick ? 13'd0 : tick_div_ff + 13'd1;
      if (!run) begin
        rate_cnt_ff <= 16'h0000;
      end else if (sample_tick) begin
        rate_cnt_ff <= (rate_cnt_ff == 16'h0000) ? rate_ff : rate_cnt_ff - 16'h0001;
      end
      if (nxt_state == ST_DELAY && state_ff != ST_DELAY) begin
        slot_b_ff <= (state_ff == ST_CALC) ? 1'b1 : ~a_en;
      end
      // sleep gate latches once the minimum has elapsed
      if (state_ff == ST_SLEEP && last_us) begin
        sleep_done_ff <= 1'b1;
      end else if (state_ff != ST_SLEEP) begin
        sleep_done_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // pins toward emitters and front end
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      SLOT_A_EMITTER_PULSE_O <= 1'b0;
      SLOT_B_EMITTER_PULSE_O <= 1'b0;
      FRONT_END_ON_O         <= 1'b0;
      SLOT_B_ACTIVE_O        <= 1'b0;
    end else begin
      SLOT_A_EMITTER_PULSE_O <= (nxt_state == ST_PULSE) & ~slot_b_ff;
      SLOT_B_EMITTER_PULSE_O <= (nxt_state == ST_PULSE) & slot_b_ff;
      FRONT_END_ON_O         <= (nxt_state != ST_IDLE) && (nxt_state != ST_SLEEP);
      SLOT_B_ACTIVE_O        <= slot_b_ff;
    end
  end

  wire [3:0] sw_code = slot_b_ff ? switch_ff[`DTSS_SW_B_HI:`DTSS_SW_B_LO]
                                 : switch_ff[`DTSS_SW_A_HI:`DTSS_SW_A_LO];

  dtss_input_switch u_switch (
    .code_i (sw_code),
    .ch1_o  (CH1_SEL_O),
    .ch2_o  (CH2_SEL_O),
    .ch3_o  (CH3_SEL_O),
    .ch4_o  (CH4_SEL_O)
  );

  // ============================================================
  // bus slave, results and fifo
  wire fifo_pop  = rd_go && idx == `DTSS_IDX_FIFO && !f_empty;
  // overflow drops the newest word; result registers still update
  wire fifo_push = capture_go && !f_full;

  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      rate_ff     <= `DTSS_RST_RATE;
      switch_ff   <= `DTSS_RST_SWITCH;
      a_delay_ff  <= `DTSS_RST_DELAY;
      a_pulse_ff  <= `DTSS_RST_PULSE;
      b_delay_ff  <= `DTSS_RST_DELAY;
      b_pulse_ff  <= `DTSS_RST_PULSE;
      ctrl_ff     <= `DTSS_RST_CTRL;
      a_result_ff <= 16'h0000;
      b_result_ff <= 16'h0000;
      ack_ff      <= 1'b0;
      WB_DAT_O    <= 32'h0000_0000;
      wr_ptr_ff   <= {(FIFO_AW+1){1'b0}};
      rd_ptr_ff   <= {(FIFO_AW+1){1'b0}};
    end else begin
      ack_ff <= req;
      if (wr_go) begin
        case (idx)
          `DTSS_IDX_RATE:    rate_ff    <= merge16(rate_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_SWITCH:  switch_ff  <= merge16(switch_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_A_DELAY: a_delay_ff <= merge16(a_delay_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_A_PULSE: a_pulse_ff <= merge16(a_pulse_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_B_DELAY: b_delay_ff <= merge16(b_delay_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_B_PULSE: b_pulse_ff <= merge16(b_pulse_ff, WB_DAT_I, WB_SEL_I);
          `DTSS_IDX_CTRL: begin
            if (WB_SEL_I[0]) begin
              ctrl_ff <= WB_DAT_I[2:0];
            end
          end
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
      if (rd_go) begin
        case (idx)
          `DTSS_IDX_RATE:     WB_DAT_O <= {16'h0000, rate_ff};
          `DTSS_IDX_SWITCH:   WB_DAT_O <= {16'h0000, switch_ff};
          `DTSS_IDX_A_DELAY:  WB_DAT_O <= {16'h0000, a_delay_ff};
          `DTSS_IDX_A_PULSE:  WB_DAT_O <= {16'h0000, a_pulse_ff};
          `DTSS_IDX_B_DELAY:  WB_DAT_O <= {16'h0000, b_delay_ff};
          `DTSS_IDX_B_PULSE:  WB_DAT_O <= {16'h0000, b_pulse_ff};
          `DTSS_IDX_CTRL:     WB_DAT_O <= {29'h0000_0000, ctrl_ff};
          `DTSS_IDX_STATUS:   WB_DAT_O <= {16'h0000, f_full, f_empty, 9'h000, slot_b_ff, 1'b0, state_ff};
          `DTSS_IDX_A_RESULT: WB_DAT_O <= {16'h0000, a_result_ff};
          `DTSS_IDX_B_RESULT: WB_DAT_O <= {16'h0000, b_result_ff};
          // bit 16 tags slot B, bit 31 flags an empty pop
          `DTSS_IDX_FIFO:     WB_DAT_O <= f_empty ? 32'h8000_0000
                                                  : {15'h0000, fifo_mem[rd_ptr_ff[FIFO_AW-1:0]]};
          default:            WB_DAT_O <= 32'h0000_0000;
        endcase
      end
      // distinct result per slot, copied to fifo
      if (capture_go) begin
        if (slot_b_ff) begin
          b_result_ff <= ADC_DATA_I;
        end else begin
          a_result_ff <= ADC_DATA_I;
        end
      end
      if (fifo_push) begin
        fifo_mem[wr_ptr_ff[FIFO_AW-1:0]] <= {slot_b_ff, ADC_DATA_I};
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// ---- test/dtss_front_end_model.sv ----
// Purpose: converter side of the front end, one value per slot
// Assumes: value is taken while the front end is on
// Notes:   toggles when off so a stale capture shows
`timescale 1ns/1ns
module dtss_front_end_model (
  input  wire logic        clk_i,
  input  wire logic        fe_on_i,
  input  wire logic        b_slot_i,
  input  wire logic [15:0] a_val_i,
  input  wire logic [15:0] b_val_i,
  output logic      [15:0] adc_o
);
  initial adc_o = 16'h0000;
  always @(posedge clk_i) begin
    if (fe_on_i) adc_o <= b_slot_i ? b_val_i : a_val_i;
    else adc_o <= ~adc_o;
  end
endmodule

// ---- test/dtss_sequencer_bench.sv ----
// Purpose: self-checking bench for the dual slot sequencer
// Assumes: rate 0, so a period starts on the first tick after sleep
// Notes:   times compared in clock cycles, small latency slack on slot edges
`timescale 1ns/1ns
`include "dtss_map.vh"
module dtss_sequencer_bench;
  localparam int US = `DTSS_US_CYC;
  localparam logic [7:0]  RI [0:6] = '{8'h12, 8'h14, 8'h30, 8'h31, 8'h35, 8'h36, 8'h40};
  localparam logic [31:0] RV [0:6] = '{32'h0000_0020, 32'h0000_0000, 32'h0000_0020, 32'h0000_0113,
                                       32'h0000_0020, 32'h0000_0113, 32'h0000_0006};
  localparam logic [31:0] SWT [0:7] = '{32'h0000_0000, 32'h0000_030C, 32'h0000_30C0, 32'h0000_000F,
                                        32'h8040_2010, 32'h0804_0201, 32'h0000_300C, 32'h0000_00F0};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic        ack, pa, pb, fe, sb;
  logic [7:0]  ch1, ch2, ch3, ch4;
  logic [15:0] adc;
  logic [15:0] av = 16'h0000;
  logic [15:0] bv = 16'h0000;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          now = 0;
  int          fe_r[$], fe_f[$], a_r[$], a_f[$], b_r[$], sb_r[$];
  logic [31:0] chb[$], fq[$];
  always #4 clk = ~clk;
  dtss_sequencer u_dut (
    .MCLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .ADC_DATA_I(adc),
    .SLOT_A_EMITTER_PULSE_O(pa), .SLOT_B_EMITTER_PULSE_O(pb), .FRONT_END_ON_O(fe), .SLOT_B_ACTIVE_O(sb),
    .CH1_SEL_O(ch1), .CH2_SEL_O(ch2), .CH3_SEL_O(ch3), .CH4_SEL_O(ch4));
  dtss_front_end_model u_afe (.clk_i(clk), .fe_on_i(fe), .b_slot_i(sb), .a_val_i(av), .b_val_i(bv), .adc_o(adc));
  // ====
  // edge log
  always @(posedge clk) begin
    now++;
    if ($rose(fe)) fe_r.push_back(now);
    if ($fell(fe)) fe_f.push_back(now);
    if ($rose(pa)) a_r.push_back(now);
    if ($fell(pa)) a_f.push_back(now);
    if ($rose(pb)) b_r.push_back(now);
    if ($rose(sb)) sb_r.push_back(now);
    if ($rose(sb)) chb.push_back({ch4, ch3, ch2, ch1});
  end
  // ====
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    chk(nm, e, (g >= e - 2 && g <= e + 2) ? e : g);
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    wb(1'b1, i, d, 4'h3);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string nm);
    wb(1'b0, i, 32'h0000_0000, 4'hF);
    chk(nm, e, q);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    int k, p1end;
    logic [3:0] a, b;
    void'($urandom(32'h6903));
    av = 16'($urandom);
    bv = 16'($urandom);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 7; k++) rd(RI[k], RV[k], "reset value");
    wr(8'h20, 32'h0000_FFFF);
    rd(8'h20, 32'h0000_0000, "unmapped");
    wb(1'b1, 8'h12, 32'h0000_ABCD, 4'h1);
    rd(8'h12, 32'h0000_00CD, "rate lane");
    for (k = 0; k < 9; k++) begin
      a = (k == 8) ? 4'($urandom_range(15, 8)) : 4'(k);
      b = 4'($urandom);
      wr(8'h14, {20'h00000, b, a, 4'h0});
      rd(8'h14, {20'h00000, b, a, 4'h0}, "switch reg");
      chk("slot a channels", a[3] ? 32'h0000_0000 : SWT[a[2:0]], {ch4, ch3, ch2, ch1});
    end
    wr(8'h30, 32'h0000_0017);
    wr(8'h31, 32'h0000_0213);
    wr(8'h35, 32'h0000_0017);
    wr(8'h36, 32'h0000_0113);
    wr(8'h14, 32'h0000_0450);
    wr(8'h12, 32'h0000_0000);
    wr(8'h40, 32'h0000_0007);
    while (fe_f.size() == 0 || sb_r.size() == 0 || fe_f[$] <= sb_r[0]) @(posedge clk);
    p1end = fe_f[$];
    fq.push_back({16'h0000, av});
    fq.push_back({15'h0000, 1'b1, bv});
    chk("a pulses", 2, a_r.size());
    near("a lead", 23 * US, a_r[0] - fe_r[0]);
    chk("a spacing", 19 * US, a_r[1] - a_r[0]);
    chk("a width", 4 * US, a_f[0] - a_r[0]);
    near("a slot time", (23 + 2 * 19 + 68) * US, sb_r[0] - fe_r[0]);
    near("b slot time", (23 + 19 + 20) * US, p1end - sb_r[0]);
    chk("slot b channels", SWT[4], chb[0]);
    rd(8'h42, {16'h0000, av}, "a result");
    rd(8'h43, {16'h0000, bv}, "b result");
    bv = ~bv;
    wr(8'h40, 32'h0000_0005);
    while (fe_f[$] == p1end) @(posedge clk);
    fq.push_back({15'h0000, 1'b1, bv});
    chk("a pulses", 2, a_r.size());
    near("b lead", 23 * US, b_r[$] - fe_r[$]);
    near("b only time", (23 + 19 + 20) * US, fe_f[$] - fe_r[$]);
    chk("sleep", 1, fe_r[$] - p1end >= 222 * US);
    chk("period grid", 0, (fe_r[$] - fe_r[0]) % `DTSS_SAMPLE_CYC);
    rd(8'h43, {16'h0000, bv}, "b result");
    while (fq.size() > 0) rd(8'h44, fq.pop_front(), "fifo word");
    rd(8'h44, 32'h8000_0000, "fifo empty");
    rd(8'h41, 32'h0000_4015, "status");
    finish_test;
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
endmodule

// ---- test/dtss_sequencer_props.sv ----
// Purpose: port checks for the dual slot sequencer
// Assumes: 125 MHz clock, 4 us emitter pulse, ack one cycle after a request
// Notes:   sleep and compute floors use helper counters
`timescale 1ns/1ns
module dtss_sequencer_props (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic SLOT_A_EMITTER_PULSE_O,
  input wire logic SLOT_B_EMITTER_PULSE_O,
  input wire logic FRONT_END_ON_O,
  input wire logic SLOT_B_ACTIVE_O
);
  localparam logic [15:0] PULSE = 16'h01F4;
  localparam logic [15:0] SLEEP = 16'h6C66;
  localparam logic [15:0] T1    = 16'h2134;
  localparam logic [15:0] T2    = 16'h09C4;
  logic [15:0] hi_cnt_ff;
  logic [15:0] lo_cnt_ff;
  logic [15:0] since_ff;
  logic        last_b_ff;
  wire         pa = SLOT_A_EMITTER_PULSE_O;
  wire         pb = SLOT_B_EMITTER_PULSE_O;
  wire         fe = FRONT_END_ON_O;
  wire         sb = SLOT_B_ACTIVE_O;
  // ====
  // helpers
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      hi_cnt_ff <= 16'h0000;
      lo_cnt_ff <= SLEEP;
      since_ff  <= 16'hFFFF;
      last_b_ff <= 1'b0;
    end else begin
      hi_cnt_ff <= (pa || pb) ? hi_cnt_ff + 16'h0001 : 16'h0000;
      // reset loads SLEEP and the count saturates there, so the first period after reset is not judged
      lo_cnt_ff <= fe ? 16'h0000 : (lo_cnt_ff < SLEEP ? lo_cnt_ff + 16'h0001 : SLEEP);
      since_ff  <= (pa || pb) ? 16'h0000 : (since_ff != 16'hFFFF ? since_ff + 16'h0001 : since_ff);
      last_b_ff <= (pa || pb) ? pb : last_b_ff;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence seq_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence seq_pulse_end;
    $fell(pa || pb);
  endsequence
  chk_ack_latency: assert property (seq_req |=> WB_ACK_O)
    else $error("ack missing after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  chk_pulse_width: assert property (seq_pulse_end |-> hi_cnt_ff == PULSE)
    else $error("emitter pulse width wrong");
  chk_slots_apart: assert property (!(pa && pb))
    else $error("both emitters on");
  chk_a_in_slot: assert property (pa |-> fe && !sb)
    else $error("slot a pulse outside slot a");
  chk_b_in_slot: assert property (pb |-> fe && sb)
    else $error("slot b pulse outside slot b");
  chk_sleep_floor: assert property ($rose(fe) |-> lo_cnt_ff < 16'h0004 || lo_cnt_ff >= SLEEP)
    else $error("sleep too short");
  chk_compute_tail: assert property ($fell(fe) |-> since_ff >= (last_b_ff ? T2 : T1))
    else $error("compute interval too short");
  chk_reset_quiet: assert property ($rose(RST_N_I) |-> !(pa || pb || fe || sb || WB_ACK_O))
    else $error("outputs active after reset");
endmodule
bind dtss_sequencer dtss_sequencer_props u_props (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .SLOT_A_EMITTER_PULSE_O(SLOT_A_EMITTER_PULSE_O), .SLOT_B_EMITTER_PULSE_O(SLOT_B_EMITTER_PULSE_O),
  .FRONT_END_ON_O(FRONT_END_ON_O), .SLOT_B_ACTIVE_O(SLOT_B_ACTIVE_O)
);
